// [sac_control.sv]
// Output queue and converter control pins of a 16-bit sampling converter.
// Assumes pins arrive asynchronously; the shift clock comes from the host.
`timescale 1ns/1ps

module sac_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign in_ready = (count_r != (AW+1)'(D));
  assign out_valid = (count_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rd_ptr_r];

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(D - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(D - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : sac_fifo

module sac_control (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic shift_clk,
  input wire logic reset_in,
  input wire logic power_down_in,
  input wire logic convert_start_n,
  input wire logic select_n,
  input wire logic read_n,
  input wire logic ref_power_down,
  input wire logic refbuffer_power_down,
  input wire logic port_type_select,
  input wire logic clock_source_select,
  input wire logic shift_clock_polarity,
  input wire logic [sac_pkg::WORD_W-1:0] sample_code,
  output logic busy,
  output logic hold_mode,
  output logic powered_down,
  output logic ref_enable,
  output logic refbuffer_enable,
  output logic result_ready,
  output logic [sac_pkg::WORD_W-1:0] parallel_data,
  output logic parallel_oe,
  output logic serial_result_out,
  output logic serial_oe,
  output logic read_overrun_flag
);

  import sac_pkg::*;

  logic rst_meta_r;
  logic rst_n_r;
  sac_pins_t pins_raw;
  sac_pins_t pins_meta_r;
  sac_pins_t pins_r;
  sac_pins_t pins_prev_r;
  sac_state_t state_r;
  logic [TIMER_W-1:0] timer_r;
  logic [WORD_W-1:0] held_code_r;
  logic start_edge;
  logic reset_fall;
  logic conv_done;
  logic push_valid;
  logic push_ready;
  logic head_valid;
  logic head_pop;
  logic [WORD_W-1:0] head_word;
  logic slave_mode;
  logic bus_on;
  logic par_read_end;
  logic frame_active_r;
  logic sclk_eff;
  logic [BIT_IDX_W-1:0] bit_idx_r;
  logic ser_bit_r;
  logic done_tog_r;
  logic done_meta_r;
  logic done_sync_r;
  logic done_prev_r;
  logic ser_read_end;
  logic overrun;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Pin group gathered into one carrier
  assign pins_raw = '{
    reset_in: reset_in,
    power_down_in: power_down_in,
    convert_start_n: convert_start_n,
    select_n: select_n,
    read_n: read_n,
    ref_power_down: ref_power_down,
    refbuffer_power_down: refbuffer_power_down,
    port_type_select: port_type_select,
    clock_source_select: clock_source_select
  };

  // Two-flop pin synchroniser, third stage for edges
  always_ff @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pins_meta_r <= PINS_RST;
      pins_r <= PINS_RST;
      pins_prev_r <= PINS_RST;
    end
    else
    begin
      pins_meta_r <= pins_raw;
      pins_r <= pins_meta_r;
      pins_prev_r <= pins_r;
    end
  end

  // Edge events on the synchronised pins and the result push handshake
  assign start_edge = pins_prev_r.convert_start_n
    && !pins_r.convert_start_n;
  assign reset_fall = pins_prev_r.reset_in && !pins_r.reset_in;
  assign push_valid = (state_r == ST_PUSH)
    && !pins_r.reset_in;
  assign conv_done = push_valid && push_ready;

  // Conversion and calibration sequencer
  always_ff @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= ST_IDLE;
      timer_r <= '0;
      held_code_r <= DATA_RST;
    end
    else if (pins_r.reset_in)
    begin
      state_r <= ST_IDLE;
      timer_r <= '0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (reset_fall)
          begin
            state_r <= ST_CAL;
            timer_r <= TIMER_W'(CAL_CYC - 1);
          end
          else if (start_edge && !pins_r.power_down_in)
          begin
            state_r <= ST_CONV;
            timer_r <= TIMER_W'(CONV_CYC - 1);
            held_code_r <= sample_code;
          end
        end
        ST_CAL:
        begin
          if (timer_r == '0)
          begin
            state_r <= ST_IDLE;
          end
          else
          begin
            timer_r <= timer_r - 1'b1;
          end
        end
        ST_CONV:
        begin
          // Start edges here are ignored
          if (timer_r == '0)
          begin
            state_r <= ST_PUSH;
          end
          else
          begin
            timer_r <= timer_r - 1'b1;
          end
        end
        ST_PUSH:
        begin
          if (push_ready)
          begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Busy, hold and power status outputs
  always_ff @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      busy <= 1'b0;
      hold_mode <= 1'b0;
      powered_down <= 1'b0;
    end
    else
    begin
      busy <= !pins_r.reset_in && ((state_r == ST_CAL && timer_r != '0)
        || (state_r == ST_CONV) || (state_r == ST_PUSH && !push_ready)
        || (state_r == ST_IDLE && (reset_fall
        || (start_edge && !pins_r.power_down_in))));
      hold_mode <= (state_r == ST_CONV);
      powered_down <= pins_r.power_down_in && (state_r != ST_CONV)
        && (state_r != ST_PUSH);
    end
  end

  // Reference and buffer power controls
  always_ff @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      ref_enable <= 1'b0;
      refbuffer_enable <= 1'b0;
    end
    else
    begin
      ref_enable <= !pins_r.ref_power_down;
      refbuffer_enable <= !pins_r.refbuffer_power_down;
    end
  end

  // Result queue between conversions and reads
  sac_fifo #(
    .W(WORD_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_n_r),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(held_code_r),
    .out_valid(head_valid),
    .out_ready(head_pop),
    .out_data(head_word)
  );

  // Read decode
  assign slave_mode = pins_r.port_type_select
    && pins_r.clock_source_select;
  assign bus_on = !pins_r.select_n && !pins_r.read_n;
  assign par_read_end = !pins_r.port_type_select && !pins_r.select_n
    && pins_r.read_n && !pins_prev_r.read_n;
  assign ser_read_end = done_sync_r != done_prev_r;
  assign overrun = conv_done && frame_active_r && !ser_read_end;
  assign head_pop = head_valid && (par_read_end || ser_read_end
    || overrun);

  // Output bus enables, parallel word and result-ready flag
  always_ff @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      parallel_oe <= 1'b0;
      serial_oe <= 1'b0;
      parallel_data <= DATA_RST;
      result_ready <= 1'b0;
    end
    else
    begin
      parallel_oe <= bus_on && !pins_r.port_type_select;
      serial_oe <= bus_on && slave_mode;
      parallel_data <= head_word;
      result_ready <= head_valid;
    end
  end

  // Slave read frame tracking and overrun pulse
  always_ff @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      frame_active_r <= 1'b0;
      read_overrun_flag <= 1'b0;
    end
    else
    begin
      read_overrun_flag <= overrun;
      if (!slave_mode || pins_r.select_n || ser_read_end || overrun)
      begin
        frame_active_r <= 1'b0;
      end
      else if (pins_prev_r.select_n && head_valid)
      begin
        frame_active_r <= 1'b1;
      end
    end
  end

  // Active shift edge chosen by polarity strap
  assign sclk_eff = shift_clk ^ shift_clock_polarity;

  // Shifter held cleared while deselected
  always_ff @(posedge sclk_eff or posedge select_n)
  begin
    if (select_n)
    begin
      bit_idx_r <= BIT_IDX_RST;
      ser_bit_r <= 1'b0;
    end
    else if (bit_idx_r != BIT_IDX_W'(WORD_W))
    begin
      ser_bit_r <= head_word[4'(WORD_W - 1) - bit_idx_r[3:0]];
      bit_idx_r <= bit_idx_r + 1'b1;
    end
  end

  assign serial_result_out = ser_bit_r;

  // Word-done toggle on the shift clock
  always_ff @(posedge sclk_eff or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      done_tog_r <= 1'b0;
    end
    else if (!select_n && bit_idx_r == BIT_IDX_W'(WORD_W - 1))
    begin
      done_tog_r <= !done_tog_r;
    end
  end

  // Done toggle brought into the reference domain
  always_ff @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      done_meta_r <= 1'b0;
      done_sync_r <= 1'b0;
      done_prev_r <= 1'b0;
    end
    else
    begin
      done_meta_r <= done_tog_r;
      done_sync_r <= done_meta_r;
      done_prev_r <= done_sync_r;
    end
  end

endmodule : sac_control

// [sac_control_chk.sv]
// Pin-level checks for the converter control block.
// Assumes a bind into sac_control; pins change just after ref_clk edges.
`timescale 1ns/1ps
module sac_control_chk (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic reset_in,
  input wire logic select_n,
  input wire logic read_n,
  input wire logic ref_power_down,
  input wire logic busy,
  input wire logic hold_mode,
  input wire logic powered_down,
  input wire logic ref_enable,
  input wire logic result_ready,
  input wire logic parallel_oe,
  input wire logic serial_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Bus drive, release, sequencing, sleep and reference relations
  property p_bus; parallel_oe || serial_oe |-> $past(!select_n && !read_n, 3);
  endproperty
  a_bus: assert property (p_bus) else $error("bus on unselected");
  property p_free; $rose(read_n) |-> ##[1:4] !parallel_oe;
  endproperty
  a_free: assert property (p_free) else $error("bus held");
  property p_cal; $fell(reset_in) |-> ##[2:5] $rose(busy);
  endproperty
  a_cal: assert property (p_cal) else $error("no calibration");
  property p_abort; $rose(reset_in) |-> ##[1:6] (!busy && !hold_mode);
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_conv; disable iff (!arst_n || reset_in)
    $rose(hold_mode) |-> ##99 (hold_mode ##1 !hold_mode);
  endproperty
  a_conv: assert property (p_conv) else $error("hold length");
  property p_ready; $rose(result_ready) |-> $past(busy, 2) && !$past(busy);
  endproperty
  a_ready: assert property (p_ready) else $error("busy vs data");
  property p_sleep; powered_down |-> !hold_mode;
  endproperty
  a_sleep: assert property (p_sleep) else $error("converts asleep");
  property p_ref; $stable(ref_power_down) [*8] |-> ref_enable != ref_power_down;
  endproperty
  a_ref: assert property (p_ref) else $error("reference state");
  // Main scenarios reached
  c_conv: cover property ($fell(hold_mode));
  c_ser: cover property ($rose(serial_oe));
  c_sleep: cover property ($rose(powered_down));
endmodule : sac_control_chk
bind sac_control sac_control_chk sac_control_chk_i (.*);

// [sac_host_model.sv]
// Host that clocks one 16-bit serial word out of the converter.
// Assumes normal polarity: data moves on rise, taken on fall.
`timescale 1ns/1ps
module sac_host_model (
  input wire logic go,
  input wire logic serial_result_out,
  output logic shift_clk,
  output logic [15:0] word,
  output logic done
);
  initial
  begin
    shift_clk = 0;
    word = 16'h0000;
    done = 0;
  end
  // 16 clocks of 125 ns per frame, clock still between frames
  always @(posedge go)
  begin
    done = 0;
    #1.3;
    repeat (16)
    begin
      #62.5 shift_clk = 1;
      #62.5 shift_clk = 0;
      word = {word[14:0], serial_result_out};
    end
    done = 1;
  end
endmodule : sac_host_model

// [sac_pkg.sv]
// Shared constants and types for the converter control-pin block.
// Assumes a 200 MHz reference clock and a 16-bit conversion result.
package sac_pkg;

  // Reference clock period
  localparam int CLK_PERIOD_PS = 5000;

  // Result word and output queue shape
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int BIT_IDX_W = 5;

  // Conversion and calibration durations, least times
  localparam int CONV_TIME_NS = 500;
  localparam int CAL_TIME_NS = 1000;

  // Cycle counts derived from the times, rounded up
  localparam int CONV_CYC =
    (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CAL_CYC =
    (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TIMER_W = 16;

  // Reset values of the parallel data word and the shift bit index
  localparam logic [WORD_W-1:0] DATA_RST = 16'h0000;
  localparam logic [BIT_IDX_W-1:0] BIT_IDX_RST = 5'h00;

  // Control pins sampled from outside the clock domain
  typedef struct packed {
    logic reset_in;
    logic power_down_in;
    logic convert_start_n;
    logic select_n;
    logic read_n;
    logic ref_power_down;
    logic refbuffer_power_down;
    logic port_type_select;
    logic clock_source_select;
  } sac_pins_t;

  // Idle levels of the pins, so no false edge follows reset
  localparam sac_pins_t PINS_RST = '{
    reset_in: 1'b0,
    power_down_in: 1'b0,
    convert_start_n: 1'b1,
    select_n: 1'b1,
    read_n: 1'b1,
    ref_power_down: 1'b0,
    refbuffer_power_down: 1'b0,
    port_type_select: 1'b0,
    clock_source_select: 1'b0
  };

  // Conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CAL,
    ST_CONV,
    ST_PUSH
  } sac_state_t;

endpackage : sac_pkg

// [tb_top.sv]
// Self-checking bench for the converter control block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_top;
  import sac_pkg::*;
  logic ref_clk = 0, arst_n = 0, reset_in = 0, power_down_in = 0;
  logic convert_start_n = 1, select_n = 1, read_n = 1, go = 0;
  logic ref_power_down = 0, refbuffer_power_down = 0;
  logic port_type_select = 0, clock_source_select = 0;
  logic shift_clock_polarity = 0;
  logic [WORD_W-1:0] sample_code = 16'h0000;
  logic shift_clk, busy, hold_mode, powered_down, ref_enable, done;
  logic refbuffer_enable, result_ready, parallel_oe, serial_result_out;
  logic serial_oe, read_overrun_flag;
  logic [WORD_W-1:0] parallel_data, word;
  int fail_count = 0;
  int compares = 0;
  int n;
  sac_control sac_control_i (.*);
  sac_host_model sac_host_model_i (.*);
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Count cycles until busy shows the wanted level
  task automatic wait_busy(input logic v);
    n = 0;
    while (busy !== v && n < 400)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_busy
  task automatic start(input logic [15:0] code);
    @(posedge ref_clk);
    sample_code <= code;
    convert_start_n <= 0;
    @(posedge ref_clk);
    convert_start_n <= 1;
    @(negedge ref_clk);
  endtask : start
  task automatic t_conv(input logic [15:0] code);
    start(code);
    wait_busy(1);
    wait_busy(0);
    chk(n[15:0], 16'(CONV_CYC + 1));
    @(negedge ref_clk);
    chk(result_ready, 1);
  endtask : t_conv
  task automatic t_pread(input logic [15:0] code);
    @(posedge ref_clk);
    select_n <= 0;
    read_n <= 0;
    repeat (5) @(negedge ref_clk);
    chk(parallel_oe, 1);
    chk(parallel_data, code);
    @(posedge ref_clk);
    read_n <= 1;
    repeat (5) @(negedge ref_clk);
    chk(parallel_oe, 0);
    @(posedge ref_clk);
    select_n <= 1;
  endtask : t_pread
  // Abort by reset, refused start, then calibration length
  task automatic t_cal;
    start(16'h1234);
    repeat (20) @(posedge ref_clk);
    reset_in <= 1;
    repeat (10) @(negedge ref_clk);
    chk(busy, 0);
    start(16'h4321);
    @(posedge ref_clk);
    reset_in <= 0;
    @(negedge ref_clk);
    wait_busy(1);
    wait_busy(0);
    chk(n[15:0], 16'(CAL_CYC));
    chk(result_ready, 0);
  endtask : t_cal
  // Fill the queue, one more stalls busy, drain in order
  task automatic t_fifo;
    for (int i = 0; i < FIFO_DEPTH; i++) t_conv(16'ha000 + 16'(i));
    start(16'h0bee);
    repeat (300) @(negedge ref_clk);
    chk(busy, 1);
    for (int i = 0; i < FIFO_DEPTH; i++) t_pread(16'ha000 + 16'(i));
    t_pread(16'h0bee);
    chk(result_ready, 0);
  endtask : t_fifo
  // Power-down mid conversion: it ends, next start refused
  task automatic t_sleep;
    start(16'h5a5a);
    @(posedge ref_clk);
    power_down_in <= 1;
    wait_busy(1);
    wait_busy(0);
    chk(n[15:0], 16'(CONV_CYC + 1));
    start(16'h0f0f);
    repeat (20) @(negedge ref_clk);
    chk(busy, 0);
    chk(powered_down, 1);
    @(posedge ref_clk);
    power_down_in <= 0;
    t_pread(16'h5a5a);
  endtask : t_sleep
  task automatic t_ref;
    logic [1:0] cfg [3] = '{2'b01, 2'b11, 2'b00};
    foreach (cfg[i])
    begin
      @(posedge ref_clk);
      {refbuffer_power_down, ref_power_down} <= cfg[i];
      repeat (10) @(negedge ref_clk);
      chk(ref_enable, !cfg[i][0]);
      chk(refbuffer_enable, !cfg[i][1]);
    end
  endtask : t_ref
  task automatic frame;
    @(posedge ref_clk);
    go <= 1;
    @(posedge ref_clk);
    go <= 0;
    n = 0;
    while (done !== 1 && n < 1000)
    begin
      @(negedge ref_clk);
      n++;
    end
    repeat (5) @(negedge ref_clk);
  endtask : frame
  // Slave serial: unselected clocks ignored, then a full word
  task automatic t_ser;
    @(posedge ref_clk);
    port_type_select <= 1;
    clock_source_select <= 1;
    t_conv(16'hc3a5);
    frame;
    chk(result_ready, 1);
    @(posedge ref_clk);
    select_n <= 0;
    read_n <= 0;
    repeat (5) @(negedge ref_clk);
    chk(serial_oe, 1);
    chk(parallel_oe, 0);
    frame;
    chk(word, 16'hc3a5);
    chk(result_ready, 0);
    @(posedge ref_clk);
    select_n <= 1;
    read_n <= 1;
    repeat (5) @(negedge ref_clk);
    chk(serial_oe, 0);
  endtask : t_ser
  // Slave read left open across a conversion end: word lost, flag pulses
  task automatic t_ovr;
    t_conv(16'h1111);
    @(posedge ref_clk);
    select_n <= 0;
    read_n <= 0;
    repeat (5) @(negedge ref_clk);
    start(16'h2222);
    n = 0;
    while (read_overrun_flag !== 1 && n < 300)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(read_overrun_flag, 1);
    @(posedge ref_clk);
    select_n <= 1;
    read_n <= 1;
    repeat (5) @(negedge ref_clk);
    @(posedge ref_clk);
    select_n <= 0;
    read_n <= 0;
    repeat (5) @(negedge ref_clk);
    frame;
    chk(word, 16'h2222);
    @(posedge ref_clk);
    select_n <= 1;
    read_n <= 1;
  endtask : t_ovr
  task automatic give_verdict;
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // Main sequence after 10 cycles of reset
  initial
  begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1;
    repeat (5) @(posedge ref_clk);
    t_cal;
    t_conv(16'h8001);
    t_pread(16'h8001);
    t_fifo;
    t_sleep;
    t_ref;
    t_ser;
    t_ovr;
    give_verdict;
  end
  // Hang guard, well beyond the expected run
  initial
  begin
    #100us;
    fail_count++;
    give_verdict;
  end
endmodule : tb_top
